// File: rtl/ipe_pkg.sv
// Constants for the interrupt priority encoder
//------------------------------------------------------------
// Function
// R01: Request lines sampled by level, not edge
// R02: Encoded mode: line value is priority, 0 none
// R03: Requester never lowers level before acceptance
// R04: Acceptance leaves mask level bits unchanged
// R05: Mode bit 1: four independent line requests
// R06: Nonmaskable 0x1C0 level 16; encoded 0x200..0x3C0
// R07: Independent lines use codes and register D nibbles
// R08: Timer and debug codes, registers A and C
// R09: Module priorities writable, reset to zero
// R10: Equal levels resolved by fixed default ranking
// R11: One handler entry, source told by code
// R12: Software changes peripheral flags while blocked
// R13: Flag race may start entry with code zero
// R14: Priority writes while blocked, then read back
// R15: Level zero masks the source
// R16: Line requests masked by status mask level
// R17: Nonmaskable accepted unless block bit set
// R18: Mode bit resets to encoded use
// R19: Highest pending unmasked request goes to core
//------------------------------------------------------------
package ipe_pkg;
	localparam int NUM_SRC = 11;
	localparam int LINE_W = 4;
	localparam int LVL_W = 5;
	localparam int CODE_W = 12;
	localparam int PRIO_W = 16;
	localparam logic [LVL_W-1:0] LVL_NMI = 5'h10;
	localparam logic [LVL_W-1:0] LVL_NONE = 5'h00;
	localparam logic [CODE_W-1:0] CODE_NONE = 12'h000;
	localparam logic [CODE_W-1:0] CODE_NMI = 12'h1C0;
	localparam logic [CODE_W-1:0] CODE_ENC_TOP = 12'h3E0;
	localparam logic [CODE_W-1:0] CODE_LINE0 = 12'h240;
	localparam logic [CODE_W-1:0] CODE_LINE1 = 12'h2A0;
	localparam logic [CODE_W-1:0] CODE_LINE2 = 12'h300;
	localparam logic [CODE_W-1:0] CODE_LINE3 = 12'h360;
	localparam logic [CODE_W-1:0] CODE_DEBUG = 12'h600;
	localparam logic [CODE_W-1:0] CODE_TMR0 = 12'h400;
	localparam logic [CODE_W-1:0] CODE_TMR1 = 12'h420;
	localparam logic [CODE_W-1:0] CODE_TMR2 = 12'h440;
	localparam logic [CODE_W-1:0] CODE_WDOG = 12'h560;
	localparam logic [PRIO_W-1:0] PRIO_A_RST = 16'h0000;
	localparam logic [PRIO_W-1:0] PRIO_B_RST = 16'h0000;
	localparam logic [PRIO_W-1:0] PRIO_C_RST = 16'h0000;
	localparam logic [PRIO_W-1:0] PRIO_D_RST = 16'hDA74;
	localparam int NIB3 = 12;
	localparam int NIB2 = 8;
	localparam int NIB1 = 4;
	localparam int NIB0 = 0;
	localparam int SHIFT_ENC = 5;
	// Default ranking order, index 0 is highest
	localparam int SRC_NMI = 0;
	localparam int SRC_ENC = 1;
	localparam int SRC_LINE0 = 2;
	localparam int SRC_DEBUG = 6;
	localparam int SRC_TMR0 = 7;
	localparam int SRC_WDOG = 10;
	localparam int PRIO_A = 0;
	localparam int PRIO_B = 1;
	localparam int PRIO_C = 2;
	localparam int PRIO_D = 3;
endpackage : ipe_pkg

// File: rtl/ipe_irl_priority_encoder.sv
// Interrupt priority encoder for request lines and on-chip sources
`timescale 1ns/100ps
`default_nettype none
module ipe_irl_priority_encoder
	import ipe_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [LINE_W-1:0] encodedRequestLines,
	input wire logic nmiPin,
	input wire logic timer0Underflow,
	input wire logic timer1Underflow,
	input wire logic timer2Underflow,
	input wire logic debugPortReq,
	input wire logic watchdogReq,
	input wire logic blockBit,
	input wire logic [LINE_W-1:0] maskLevelBits,
	input wire logic [3:0] prioWrEn,
	input wire logic [PRIO_W-1:0] prioWrData,
	input wire logic modeWrEn,
	input wire logic modeWrData,
	input wire logic intAck,
	output logic [PRIO_W-1:0] priorityLevelRegA,
	output logic [PRIO_W-1:0] priorityLevelRegB,
	output logic [PRIO_W-1:0] priorityLevelRegC,
	output logic [PRIO_W-1:0] priorityLevelRegD,
	output logic requestLineModeSelect,
	output logic intReq,
	output logic [LVL_W-1:0] intLevel,
	output logic [CODE_W-1:0] pendingCode,
	output logic [CODE_W-1:0] eventCodeRegister
);

//------------------------------------------------------------
// Pin synchronisers
//------------------------------------------------------------
logic [LINE_W-1:0] lineMeta_ff;
logic [LINE_W-1:0] lineSync_ff;
logic nmiMeta_ff;
logic nmiSync_ff;
logic nmiPrev_ff;

always_ff @(posedge clk)
begin
	if (rst)
	begin
		lineMeta_ff <= '0;
		lineSync_ff <= '0;
		nmiMeta_ff <= 1'b0;
		nmiSync_ff <= 1'b0;
		nmiPrev_ff <= 1'b0;
	end
	else if (clkEn)
	begin
		lineMeta_ff <= encodedRequestLines;
		lineSync_ff <= lineMeta_ff; // R01
		nmiMeta_ff <= nmiPin;
		nmiSync_ff <= nmiMeta_ff;
		nmiPrev_ff <= nmiSync_ff;
	end
end

//------------------------------------------------------------
// Priority and mode registers
//------------------------------------------------------------
logic [PRIO_W-1:0] prioA_ff;
logic [PRIO_W-1:0] prioB_ff;
logic [PRIO_W-1:0] prioC_ff;
logic [PRIO_W-1:0] prioD_ff;
logic modeSel_ff;

always_ff @(posedge clk)
begin
	if (rst)
	begin
		prioA_ff <= PRIO_A_RST; // R09
		prioB_ff <= PRIO_B_RST;
		prioC_ff <= PRIO_C_RST;
		prioD_ff <= PRIO_D_RST;
	end
	else if (clkEn)
	begin
		if (prioWrEn[PRIO_A])
			prioA_ff <= prioWrData; // R09
		if (prioWrEn[PRIO_B])
			prioB_ff <= prioWrData;
		if (prioWrEn[PRIO_C])
			prioC_ff <= prioWrData;
		if (prioWrEn[PRIO_D])
			prioD_ff <= prioWrData;
	end
end

always_ff @(posedge clk)
begin
	if (rst)
		modeSel_ff <= 1'b0; // R18
	else if (clkEn && modeWrEn)
		modeSel_ff <= modeWrData;
end

assign priorityLevelRegA = prioA_ff;
assign priorityLevelRegB = prioB_ff;
assign priorityLevelRegC = prioC_ff;
assign priorityLevelRegD = prioD_ff;
assign requestLineModeSelect = modeSel_ff;

//------------------------------------------------------------
// Nonmaskable pending flag
//------------------------------------------------------------
logic nmiPend_ff;
logic intReq_ff;
logic [LVL_W-1:0] intLevel_ff;
logic [CODE_W-1:0] pendCode_ff;
logic [CODE_W-1:0] eventCode_ff;
logic nmiTaken;

assign nmiTaken = intAck && intReq_ff && (intLevel_ff == LVL_NMI);

always_ff @(posedge clk)
begin
	if (rst)
		nmiPend_ff <= 1'b0;
	else if (clkEn)
	begin
		if (nmiSync_ff && !nmiPrev_ff)
			nmiPend_ff <= 1'b1;
		else if (nmiTaken)
			nmiPend_ff <= 1'b0;
	end
end

//------------------------------------------------------------
// Source table
//------------------------------------------------------------
logic [NUM_SRC-1:0] srcReq;
logic [LVL_W-1:0] srcLvl [NUM_SRC];
logic [CODE_W-1:0] srcCode [NUM_SRC];
logic [CODE_W-1:0] lineCode [LINE_W];
logic [LINE_W-1:0] lineLvl [LINE_W];
logic [CODE_W-1:0] encCode;

assign lineCode[0] = CODE_LINE0;
assign lineCode[1] = CODE_LINE1;
assign lineCode[2] = CODE_LINE2;
assign lineCode[3] = CODE_LINE3;
assign lineLvl[0] = prioD_ff[NIB3 +: LINE_W]; // R07
assign lineLvl[1] = prioD_ff[NIB2 +: LINE_W];
assign lineLvl[2] = prioD_ff[NIB1 +: LINE_W];
assign lineLvl[3] = prioD_ff[NIB0 +: LINE_W];
// Level 15 maps to 0x200, each lower level adds 0x20
assign encCode = CODE_ENC_TOP - (CODE_W'(lineSync_ff) << SHIFT_ENC); // R06

assign srcReq[SRC_NMI] = nmiPend_ff;
assign srcLvl[SRC_NMI] = LVL_NMI; // R06
assign srcCode[SRC_NMI] = CODE_NMI;
assign srcReq[SRC_ENC] = !modeSel_ff && (lineSync_ff != '0); // R02
assign srcLvl[SRC_ENC] = {1'b0, lineSync_ff}; // R02
assign srcCode[SRC_ENC] = encCode;

genvar gi;
generate
	for (gi = 0; gi < LINE_W; gi++)
	begin : gLine
		assign srcReq[SRC_LINE0+gi] = modeSel_ff && lineSync_ff[gi]; // R05
		assign srcLvl[SRC_LINE0+gi] = {1'b0, lineLvl[gi]}; // R07
		assign srcCode[SRC_LINE0+gi] = lineCode[gi];
	end
endgenerate

assign srcReq[SRC_DEBUG] = debugPortReq;
assign srcLvl[SRC_DEBUG] = {1'b0, prioC_ff[NIB0 +: LINE_W]}; // R08
assign srcCode[SRC_DEBUG] = CODE_DEBUG;
assign srcReq[SRC_TMR0] = timer0Underflow;
assign srcLvl[SRC_TMR0] = {1'b0, prioA_ff[NIB3 +: LINE_W]}; // R08
assign srcCode[SRC_TMR0] = CODE_TMR0;
assign srcReq[SRC_TMR0+1] = timer1Underflow;
assign srcLvl[SRC_TMR0+1] = {1'b0, prioA_ff[NIB2 +: LINE_W]};
assign srcCode[SRC_TMR0+1] = CODE_TMR1;
assign srcReq[SRC_TMR0+2] = timer2Underflow;
assign srcLvl[SRC_TMR0+2] = {1'b0, prioA_ff[NIB1 +: LINE_W]};
assign srcCode[SRC_TMR0+2] = CODE_TMR2;
assign srcReq[SRC_WDOG] = watchdogReq;
assign srcLvl[SRC_WDOG] = {1'b0, prioB_ff[NIB3 +: LINE_W]};
assign srcCode[SRC_WDOG] = CODE_WDOG;

//------------------------------------------------------------
// Arbitration
//------------------------------------------------------------
logic nxt_intReq;
logic [LVL_W-1:0] nxt_intLevel;
logic [CODE_W-1:0] nxt_pendCode;

always_comb
begin
	nxt_intReq = 1'b0;
	nxt_intLevel = LVL_NONE;
	nxt_pendCode = CODE_NONE;
	// Strictly greater keeps the earlier source on a tie
	for (int i = 0; i < NUM_SRC; i++)
	begin
		if (srcReq[i] && (srcLvl[i] != LVL_NONE) // R15
			&& (srcLvl[i] > {1'b0, maskLevelBits}) // R16
			&& (srcLvl[i] > nxt_intLevel)) // R10 R19
		begin
			nxt_intReq = 1'b1;
			nxt_intLevel = srcLvl[i];
			nxt_pendCode = srcCode[i];
		end
	end
	if (blockBit)
	begin
		nxt_intReq = 1'b0; // R17
		nxt_intLevel = LVL_NONE;
		nxt_pendCode = CODE_NONE;
	end
end

always_ff @(posedge clk)
begin
	if (rst)
	begin
		intReq_ff <= 1'b0;
		intLevel_ff <= LVL_NONE;
		pendCode_ff <= CODE_NONE;
	end
	else if (clkEn)
	begin
		intReq_ff <= nxt_intReq;
		intLevel_ff <= nxt_intLevel;
		pendCode_ff <= nxt_pendCode;
	end
end

// Acceptance loads the code and clears a taken nonmaskable flag; the mask level is left to the core
always_ff @(posedge clk)
begin
	if (rst)
		eventCode_ff <= CODE_NONE;
	else if (clkEn && intAck)
		eventCode_ff <= intReq_ff ? pendCode_ff : CODE_NONE; // R04 R11 R13
end

assign intReq = intReq_ff;
assign intLevel = intLevel_ff;
assign pendingCode = pendCode_ff;
assign eventCodeRegister = eventCode_ff;

//------------------------------------------------------------
// Assertions
//------------------------------------------------------------
default clocking cbClk @(posedge clk); endclocking
default disable iff (rst);

AST_NO_ZERO_LEVEL: assert property (intReq_ff |-> intLevel_ff != LVL_NONE) // R15
	else $error("Request shown at level zero");
AST_BLOCKED: assert property (clkEn && blockBit |=> !intReq_ff) // R17
	else $error("Request passed while blocked");
AST_MASKED: assert property ($past(clkEn) && intReq_ff && intLevel_ff != LVL_NMI // R16
	|-> intLevel_ff > {1'b0, $past(maskLevelBits)})
	else $error("Request not above mask level");
AST_NMI_CODE: assert property (intReq_ff && intLevel_ff == LVL_NMI // R06
	|-> pendCode_ff == CODE_NMI)
	else $error("Wrong nonmaskable code");
AST_NMI_SHOWN: assert property (clkEn && !blockBit && nmiPend_ff // R17
	|=> intReq_ff && intLevel_ff == LVL_NMI && pendCode_ff == CODE_NMI)
	else $error("Pending nonmaskable request not shown");
AST_NMI_CLEAR: assert property (clkEn && nmiTaken && !(nmiSync_ff && !nmiPrev_ff) // R17
	|=> !nmiPend_ff)
	else $error("Nonmaskable flag kept after acceptance");
AST_ACK_CODE: assert property (clkEn && intAck && intReq_ff // R11
	|=> eventCode_ff == $past(pendCode_ff))
	else $error("Event code not loaded on acceptance");
AST_ACK_EMPTY: assert property (clkEn && intAck && !intReq_ff // R13
	|=> eventCode_ff == CODE_NONE)
	else $error("Empty acceptance gave nonzero code");
AST_ENC_TOP: assert property (clkEn && !blockBit && !modeSel_ff && !nmiPend_ff // R02
	&& lineSync_ff == '1 && maskLevelBits != '1
	|=> intReq_ff && pendCode_ff == 12'h200)
	else $error("Encoded level 15 not presented");
AST_IDLE_QUIET: assert property (clkEn && !nmiPend_ff && lineSync_ff == '0 // R02
	&& !debugPortReq && !timer0Underflow && !timer1Underflow && !timer2Underflow
	&& !watchdogReq |=> !intReq_ff)
	else $error("Request shown with no source active");
AST_FROZEN: assert property (!clkEn
	|=> $stable(intReq_ff) && $stable(pendCode_ff) && $stable(eventCode_ff))
	else $error("State moved while clock enable low");
// Reset checks stay armed while reset is high
AST_MODE_RESET: assert property (@(posedge clk) disable iff (1'b0) // R18
	rst |=> !modeSel_ff)
	else $error("Mode bit not cleared by reset");
AST_PRIO_RESET: assert property (@(posedge clk) disable iff (1'b0) // R07 R09
	rst |=> prioD_ff == PRIO_D_RST && prioA_ff == PRIO_A_RST
	&& prioB_ff == PRIO_B_RST && prioC_ff == PRIO_C_RST)
	else $error("Priority registers reset wrong");

// Scenario covers
COV_NMI_TAKEN: cover property (nmiTaken && clkEn);
COV_NMI_BLOCKED: cover property (nmiPend_ff && blockBit);
COV_ENC_ACK: cover property (intReq_ff && intAck && !modeSel_ff && intLevel_ff < LVL_NMI);
COV_LINE_ACK: cover property (intReq_ff && intAck && modeSel_ff);

endmodule : ipe_irl_priority_encoder
`default_nettype wire

// File: sim/ipe_partner.sv
// Model of the external requester and the accepting core
`timescale 1ns/100ps
`default_nettype none
module ipe_partner
	import ipe_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [LINE_W-1:0] wantLevel,
	input wire logic acceptEn,
	input wire logic intReq,
	output logic [LINE_W-1:0] reqLines,
	output logic intAck
);
	always_ff @(negedge clk)
	begin
		if (rst)
		begin
			reqLines <= 4'h0;
			intAck <= 1'b0;
		end
		else
		begin
			// Only raise until the core has taken it
			if (wantLevel > reqLines || intAck)
				reqLines <= wantLevel;
			intAck <= acceptEn && intReq && !intAck;
		end
	end
endmodule : ipe_partner
`default_nettype wire

// File: sim/ipe_irl_priority_encoder_bench.sv
// Self-checking bench for the interrupt priority encoder
`timescale 1ns/100ps
`default_nettype none
module ipe_irl_priority_encoder_bench
	import ipe_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic nmiPin = 1'b0;
	logic [2:0] tmr = 3'h0;
	logic dbg = 1'b0;
	logic wdg = 1'b0;
	logic blockBit = 1'b0;
	logic [3:0] mask = 4'h0;
	logic [3:0] prioWrEn = 4'h0;
	logic [15:0] prioWrData = 16'h0000;
	logic modeWrEn = 1'b0;
	logic modeWrData = 1'b0;
	logic [3:0] want = 4'h0;
	logic acceptEn = 1'b0;
	logic clkEn = 1'b1;
	logic [15:0] regA, regB, regC, regD;
	logic modeSel, intReq, intAck;
	logic [4:0] intLevel;
	logic [11:0] pendCode, evtCode;
	logic [3:0] lines;
	int mismatches = 0;
	int checkCount = 0;

	always #10 clk = ~clk;

	ipe_irl_priority_encoder u_dut (.clk(clk), .rst(rst), .clkEn(clkEn),
		.encodedRequestLines(lines), .nmiPin(nmiPin), .timer0Underflow(tmr[0]),
		.timer1Underflow(tmr[1]), .timer2Underflow(tmr[2]), .debugPortReq(dbg),
		.watchdogReq(wdg), .blockBit(blockBit), .maskLevelBits(mask),
		.prioWrEn(prioWrEn), .prioWrData(prioWrData), .modeWrEn(modeWrEn),
		.modeWrData(modeWrData), .intAck(intAck), .priorityLevelRegA(regA),
		.priorityLevelRegB(regB), .priorityLevelRegC(regC), .priorityLevelRegD(regD),
		.requestLineModeSelect(modeSel), .intReq(intReq), .intLevel(intLevel),
		.pendingCode(pendCode), .eventCodeRegister(evtCode));

	ipe_partner u_far (.clk(clk), .rst(rst), .wantLevel(want), .acceptEn(acceptEn),
		.intReq(intReq), .reqLines(lines), .intAck(intAck));

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic chkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
		checkCount++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chkVal

	task automatic expReq(input logic [4:0] lvl, input logic [11:0] code);
		repeat (4) @(negedge clk);
		chkVal("intReq", {15'h0, lvl != 5'h00}, {15'h0, intReq});
		if (lvl != 5'h00)
		begin
			chkVal("intLevel", {11'h0, lvl}, {11'h0, intLevel});
			chkVal("pendingCode", {4'h0, code}, {4'h0, pendCode});
		end
	endtask : expReq

	task automatic accept(input logic [11:0] code);
		acceptEn <= 1'b1;
		repeat (2) @(negedge clk);
		acceptEn <= 1'b0;
		@(negedge clk);
		chkVal("eventCode", {4'h0, code}, {4'h0, evtCode});
	endtask : accept

	task automatic wrPrio(input int idx, input logic [15:0] val);
		blockBit = 1'b1;
		prioWrEn[idx] = 1'b1;
		prioWrData = val;
		@(negedge clk);
		prioWrEn = 4'h0;
		chkVal("prioReg", val, (idx == 0) ? regA : (idx == 1) ? regB
			: (idx == 2) ? regC : regD);
		blockBit = 1'b0;
		@(negedge clk);
	endtask : wrPrio

	task automatic setMode(input logic val);
		modeWrEn = 1'b1;
		modeWrData = val;
		@(negedge clk);
		modeWrEn = 1'b0;
		chkVal("mode", {15'h0, val}, {15'h0, modeSel});
	endtask : setMode

	task automatic setSrc(input logic [2:0] t, input logic d, input logic w);
		blockBit = 1'b1;
		tmr = t;
		dbg = d;
		wdg = w;
		@(negedge clk);
		blockBit = 1'b0;
	endtask : setSrc

	task automatic conclude();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic testReset();
		chkVal("regA", 16'h0000, regA);
		chkVal("regB", 16'h0000, regB);
		chkVal("regC", 16'h0000, regC);
		chkVal("regD", 16'hDA74, regD);
		chkVal("mode", 16'h0000, {15'h0, modeSel});
		chkVal("intReq", 16'h0000, {15'h0, intReq});
		$display("reset test done");
	endtask : testReset

	task automatic testEncoded();
		want <= 4'h9;
		mask = 4'h9;
		expReq(5'h00, 12'h000);
		mask = 4'h8;
		expReq(5'h09, 12'h2C0);
		mask = 4'h0;
		want <= 4'h0;
		accept(12'h2C0);
		expReq(5'h00, 12'h000);
		for (int l = 1; l < 16; l++)
		begin
			want <= 4'(l);
			expReq(5'(l), 12'h200 + 12'(15 - l) * 12'h20);
		end
		want <= 4'h0;
		accept(12'h200);
		expReq(5'h00, 12'h000);
		$display("encoded test done");
	endtask : testEncoded

	task automatic testLines();
		logic [4:0] lv[4] = '{5'h0D, 5'h0A, 5'h07, 5'h04};
		logic [11:0] cd[4] = '{12'h240, 12'h2A0, 12'h300, 12'h360};
		setMode(1'b1);
		for (int i = 0; i < 4; i++)
		begin
			want <= 4'(1 << i);
			expReq(lv[i], cd[i]);
		end
		want <= 4'h0;
		accept(12'h360);
		setMode(1'b0);
		expReq(5'h00, 12'h000);
		$display("independent test done");
	endtask : testLines

	task automatic testModules();
		wrPrio(0, 16'h5550);
		wrPrio(2, 16'h0005);
		chkVal("regA", 16'h5550, regA);
		chkVal("regC", 16'h0005, regC);
		setSrc(3'b001, 1'b1, 1'b0);
		expReq(5'h05, 12'h600);
		setSrc(3'b001, 1'b0, 1'b0);
		expReq(5'h05, 12'h400);
		setSrc(3'b010, 1'b0, 1'b0);
		expReq(5'h05, 12'h420);
		setSrc(3'b100, 1'b0, 1'b0);
		expReq(5'h05, 12'h440);
		wrPrio(0, 16'h5900);
		setSrc(3'b011, 1'b0, 1'b0);
		expReq(5'h09, 12'h420);
		setSrc(3'b100, 1'b0, 1'b1);
		expReq(5'h00, 12'h000);
		setSrc(3'b000, 1'b0, 1'b0);
		$display("module test done");
	endtask : testModules

	task automatic testNmi();
		blockBit = 1'b1;
		nmiPin = 1'b1;
		expReq(5'h00, 12'h000);
		blockBit = 1'b0;
		expReq(5'h10, 12'h1C0);
		accept(12'h1C0);
		expReq(5'h00, 12'h000);
		nmiPin = 1'b0;
		$display("nonmaskable test done");
	endtask : testNmi

	task automatic testRerun();
		rst <= 1'b1;
		repeat (2) @(negedge clk);
		rst <= 1'b0;
		@(negedge clk);
		testReset();
	endtask : testRerun

	task automatic testFreeze();
		clkEn = 1'b0;
		want <= 4'hC;
		expReq(5'h00, 12'h000);
		clkEn = 1'b1;
		expReq(5'h0C, 12'h260);
		want <= 4'h0;
		accept(12'h260);
		expReq(5'h00, 12'h000);
		$display("clock enable test done");
	endtask : testFreeze

	initial
	begin
		#100us;
		mismatches++;
		$display("watchdog expired");
		conclude();
	end

	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		testReset();
		testEncoded();
		testLines();
		testModules();
		testRerun();
		testNmi();
		testFreeze();
		conclude();
	end
endmodule : ipe_irl_priority_encoder_bench
`default_nettype wire
